// ---- verilog/astx_pkg.sv ----
`default_nettype none
package astx_pkg;

  // Character framing
  localparam int unsigned DATA_BITS_NARROW = 8;
  localparam int unsigned DATA_BITS_WIDE   = 9;
  localparam logic        LINE_IDLE        = 1'b1;
  localparam logic        START_LEVEL      = 1'b0;
  localparam logic        STOP_LEVEL       = 1'b1;

  // Reset values
  localparam logic [15:0] BAUD_DIV_RST     = 16'h0000;
  localparam logic [3:0]  BIT_IDX_RST      = 4'h0;

  // Baud divisor fields
  localparam int unsigned BAUD_HI_MSB      = 15;
  localparam int unsigned BAUD_HI_LSB      = 8;

  // Ticks per bit at the slow and the fast rate, per counter width
  localparam logic [5:0]  TICKS_SLOW_8     = 6'h40;
  localparam logic [5:0]  TICKS_SLOW_16    = 6'h10;
  localparam logic [5:0]  TICKS_FAST_8     = 6'h10;
  localparam logic [5:0]  TICKS_FAST_16    = 6'h04;
  localparam logic [5:0]  TICKS_RST        = 6'h00;

  typedef enum logic [1:0]
  {
    ASTX_IDLE  = 2'b00,
    ASTX_START = 2'b01,
    ASTX_DATA  = 2'b10,
    ASTX_STOP  = 2'b11
  } astx_state_e;

  // Software-visible control bits
  typedef struct packed
  {
    logic serial_port_enable;
    logic sync_mode_select;
    logic transmit_enable;
    logic nine_bit_select;
    logic ninth_data_bit;
    logic transmit_invert;
    logic high_baud_select;
    logic wide_baud_counter;
  } astx_ctrl_s;

  // Interrupt gating bits
  typedef struct packed
  {
    logic transmit_irq_enable;
    logic peripheral_irq_gate;
    logic global_irq_enable;
  } astx_irq_s;

endpackage : astx_pkg
`default_nettype wire

// ---- verilog/astx_transmitter.sv ----
`timescale 1ns/1ps
`default_nettype none
module astx_transmitter
  import astx_pkg::*;
#(
  parameter int unsigned DIV_W = 16
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Control and configuration
  input  wire astx_ctrl_s       ctrl_i,
  input  wire astx_irq_s        irq_en_i,
  input  wire logic [7:0]       baud_divisor_high_i,
  input  wire logic [7:0]       baud_divisor_low_i,
  // Holding register write
  input  wire logic             hold_wr_i,
  input  wire logic [7:0]       hold_data_i,
  // Status
  output logic                  shift_empty_flag_o,
  output logic                  transmit_buffer_flag_o,
  output logic                  transmit_irq_o,
  // Serial line
  output logic                  tx_o
);

  // Whole block state in one record
  typedef struct packed
  {
    astx_state_e      state;
    logic [8:0]       hold;
    logic             hold_full;
    logic [8:0]       shifter;
    logic [3:0]       bit_idx;
    logic [3:0]       nbits;
    logic [DIV_W-1:0] div_cnt;
    logic [5:0]       tick_cnt;
    logic             shift_empty;
    logic             buf_flag;
    logic             transmit_enable_d;
    logic             line;
  } astx_st_s;

  astx_st_s st_r;
  astx_st_s st_nxt;

  // Ticks making up one bit time for the selected rate and counter width
  function automatic logic [5:0] astx_ticks(input logic fast, input logic wide);
    logic [5:0] t;
    t = TICKS_RST;
    case ({fast, wide})
      2'b00:   t = TICKS_SLOW_8;
      2'b01:   t = TICKS_SLOW_16;
      2'b10:   t = TICKS_FAST_8;
      2'b11:   t = TICKS_FAST_16;
      default: t = TICKS_SLOW_8;
    endcase
    return t;
  endfunction : astx_ticks

  logic [15:0]      baud_div;
  logic [DIV_W-1:0] div_load;
  logic             tick;
  logic             bit_end;
  logic             async_on;

  // Divisor pair, high byte upper; the narrow counter uses only the low byte
  assign baud_div = {baud_divisor_high_i, baud_divisor_low_i};
  assign div_load = ctrl_i.wide_baud_counter ? DIV_W'(baud_div)
                                             : DIV_W'(baud_div[BAUD_HI_LSB-1:0]);
  assign tick     = (st_r.div_cnt == '0);
  assign bit_end  = tick && (st_r.tick_cnt == 6'h01);
  // Asynchronous path starts a character only with the port on, sync mode off and transmit enabled
  assign async_on = ctrl_i.serial_port_enable && !ctrl_i.sync_mode_select
                    && ctrl_i.transmit_enable;

  // Next-state logic
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.transmit_enable_d = ctrl_i.transmit_enable;

    // Baud pacing: divisor counts down to a tick, ticks count a bit time
    if (st_r.state != ASTX_IDLE)
    begin
      st_nxt.div_cnt = tick ? div_load : st_r.div_cnt - DIV_W'(1);
      if (tick)
      begin
        st_nxt.tick_cnt = (st_r.tick_cnt == 6'h01)
                          ? astx_ticks(ctrl_i.high_baud_select, ctrl_i.wide_baud_counter)
                          : st_r.tick_cnt - 6'h01;
      end
    end

    // Holding register write; ninth bit sampled here, so it must precede
    if (hold_wr_i)
    begin
      st_nxt.hold      = {ctrl_i.ninth_data_bit, hold_data_i};
      st_nxt.hold_full = 1'b1;
      st_nxt.buf_flag  = 1'b0;
    end

    // Rising transmit enable raises the buffer flag
    if (ctrl_i.transmit_enable && !st_r.transmit_enable_d && !st_r.hold_full && !hold_wr_i)
    begin
      st_nxt.buf_flag = 1'b1;
    end
    if (!ctrl_i.transmit_enable)
    begin
      st_nxt.buf_flag = 1'b0;
    end

    case (st_r.state)
      ASTX_IDLE:
      begin
        st_nxt.line = LINE_IDLE;
        // Load shifter the cycle after the write; flag rise and start together
        if (st_r.hold_full && async_on)
        begin
          st_nxt.shifter     = st_r.hold;
          st_nxt.nbits       = ctrl_i.nine_bit_select ? 4'(DATA_BITS_WIDE)
                                                      : 4'(DATA_BITS_NARROW);
          st_nxt.hold_full   = hold_wr_i;
          st_nxt.buf_flag    = !hold_wr_i;
          st_nxt.shift_empty = 1'b0;
          st_nxt.bit_idx     = BIT_IDX_RST;
          st_nxt.div_cnt     = div_load;
          st_nxt.tick_cnt    = astx_ticks(ctrl_i.high_baud_select,
                                          ctrl_i.wide_baud_counter);
          st_nxt.line        = START_LEVEL;
          st_nxt.state       = ASTX_START;
        end
      end
      ASTX_START:
      begin
        if (bit_end)
        begin
          st_nxt.line  = st_r.shifter[0];
          st_nxt.state = ASTX_DATA;
        end
      end
      ASTX_DATA:
      begin
        // Data leaves least significant bit first
        if (bit_end)
        begin
          st_nxt.shifter = {1'b0, st_r.shifter[8:1]};
          st_nxt.bit_idx = st_r.bit_idx + 4'h1;
          if (st_r.bit_idx + 4'h1 == st_r.nbits)
          begin
            st_nxt.line  = STOP_LEVEL;
            st_nxt.state = ASTX_STOP;
          end
          else
          begin
            st_nxt.line = st_r.shifter[1];
          end
        end
      end
      ASTX_STOP:
      begin
        // Empty only once the stop bit has fully gone out
        if (bit_end)
        begin
          st_nxt.shift_empty = 1'b1;
          st_nxt.line        = LINE_IDLE;
          st_nxt.state       = ASTX_IDLE;
        end
      end
      default:
      begin
        st_nxt.state = ASTX_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r.state       <= ASTX_IDLE;
      st_r.hold        <= 9'h000;
      st_r.hold_full   <= 1'b0;
      st_r.shifter     <= 9'h000;
      st_r.bit_idx     <= BIT_IDX_RST;
      st_r.nbits       <= 4'(DATA_BITS_NARROW);
      st_r.div_cnt     <= DIV_W'(BAUD_DIV_RST);
      st_r.tick_cnt    <= TICKS_RST;
      st_r.shift_empty <= 1'b1;
      st_r.buf_flag    <= 1'b0;
      st_r.transmit_enable_d      <= 1'b0;
      st_r.line        <= LINE_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs; shifter itself never leaves the block
  assign shift_empty_flag_o     = st_r.shift_empty;
  assign transmit_buffer_flag_o = st_r.buf_flag;
  assign transmit_irq_o         = st_r.buf_flag && irq_en_i.transmit_irq_enable
                                  && irq_en_i.peripheral_irq_gate
                                  && irq_en_i.global_irq_enable;
  assign tx_o                   = st_r.line ^ ctrl_i.transmit_invert;

endmodule : astx_transmitter
`default_nettype wire

// ---- verification/astx_transmitter_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module astx_transmitter_monitor
  import astx_pkg::*;
(
  // Watched ports
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire astx_ctrl_s ctrl_i,
  input wire astx_irq_s  irq_en_i,
  input wire logic       hold_wr_i,
  input wire logic       shift_empty_flag_o,
  input wire logic       transmit_buffer_flag_o,
  input wire logic       transmit_irq_o,
  input wire logic       tx_o
);
  // Load is only legal with the port on, asynchronous and enabled
  wire en = ctrl_i.serial_port_enable && !ctrl_i.sync_mode_select && ctrl_i.transmit_enable;
  logic inv;
  assign inv = ctrl_i.transmit_invert;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Empty flag never reaches the interrupt
  property p_irq; transmit_irq_o == (transmit_buffer_flag_o && irq_en_i == 3'h7); endproperty
  a_irq: assert property (p_irq) else $error("irq gating");
  property p_idle; shift_empty_flag_o |-> tx_o == (LINE_IDLE ^ inv); endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_start; $fell(shift_empty_flag_o) |-> (tx_o == (START_LEVEL ^ inv))[*4]; endproperty
  a_start: assert property (p_start) else $error("start bit");
  property p_busy; $fell(shift_empty_flag_o) |-> (!shift_empty_flag_o)[*8]; endproperty
  a_busy: assert property (p_busy) else $error("empty too soon");
  property p_load;
    hold_wr_i && en && shift_empty_flag_o && transmit_buffer_flag_o |-> ##2 $fell(shift_empty_flag_o);
  endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_dip;
    hold_wr_i && en && shift_empty_flag_o && transmit_buffer_flag_o |=> !transmit_buffer_flag_o ##1
      transmit_buffer_flag_o;
  endproperty
  a_dip: assert property (p_dip) else $error("buffer flag");
  property p_rise;
    $rose(ctrl_i.transmit_enable) && shift_empty_flag_o && !hold_wr_i |-> ##[1:2] transmit_buffer_flag_o;
  endproperty
  a_rise: assert property (p_rise) else $error("flag on enable");
  property p_off; !ctrl_i.transmit_enable |=> !transmit_buffer_flag_o; endproperty
  a_off: assert property (p_off) else $error("flag while off");
endmodule : astx_transmitter_monitor
bind astx_transmitter astx_transmitter_monitor astx_transmitter_monitor_inst (.clk_i, .nrst_i,
  .ctrl_i, .irq_en_i, .hold_wr_i, .shift_empty_flag_o, .transmit_buffer_flag_o, .transmit_irq_o, .tx_o);
`default_nettype wire

// ---- verification/astx_rx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module astx_rx_model
  import astx_pkg::*;
#(
  parameter int BT = 8
)
(
  // Line side
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       nine_i,
  // Received character
  output var  logic [8:0] data_o,
  output var  logic [7:0] count_o
);
  // Mid-bit sampling; a glitch shorter than half a bit is no start
  initial
  begin
    data_o  = 9'h000;
    count_o = 8'h00;
    forever
    begin
      @(negedge line_i);
      repeat (BT / 2) @(posedge clk_i);
      if (line_i === START_LEVEL)
      begin
        data_o = 9'h000;
        for (int i = 0; i < (nine_i ? 9 : 8); i++)
        begin
          repeat (BT) @(posedge clk_i);
          data_o[i] = line_i;
        end
        repeat (BT) @(posedge clk_i);
        if (line_i === STOP_LEVEL) count_o = count_o + 8'h01;
      end
    end
  end
endmodule : astx_rx_model
`default_nettype wire

// ---- verification/astx_transmitter_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module astx_transmitter_bench;
  import astx_pkg::*;
  localparam int BT = 8; // Four ticks times divisor of one plus one
  logic       clk_i = 1'b0, nrst_i = 1'b0, hold_wr_i = 1'b0, sef, tbf, irq, tx, line;
  logic [7:0] hold_data_i = 8'h00, cnt;
  logic [8:0] rx;
  astx_ctrl_s ctrl = 8'h03;
  astx_irq_s  irq_en = 3'h0;
  int         n_fail = 0, checked = 0;

  // Clock and the receiver's view of the line
  always #5 clk_i = ~clk_i;
  assign line = tx ^ ctrl.transmit_invert;
  astx_transmitter astx_transmitter_inst (.clk_i, .nrst_i, .ctrl_i(ctrl), .irq_en_i(irq_en),
    .baud_divisor_high_i(8'h00), .baud_divisor_low_i(8'h01), .hold_wr_i, .hold_data_i,
    .shift_empty_flag_o(sef), .transmit_buffer_flag_o(tbf), .transmit_irq_o(irq), .tx_o(tx));
  astx_rx_model #(.BT(BT)) astx_rx_model_inst (.clk_i, .line_i(line),
    .nine_i(ctrl.nine_bit_select), .data_o(rx), .count_o(cnt));

  // Compares and bus helpers
  task automatic chk_data(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({8'h00, got}, {8'h00, exp});
  endtask : chk_bit
  task automatic send(input logic [7:0] d);
    @(posedge clk_i);
    hold_wr_i   <= 1'b1;
    hold_data_i <= d;
    @(posedge clk_i);
    hold_wr_i   <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : send
  task automatic wait_rx(input logic [7:0] n);
    for (int k = 0; k < 400 && cnt != n; k++) @(posedge clk_i);
    // A character that never arrives is a failure, not a silent pass
    if (cnt !== n)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, cnt, n);
    end
  endtask : wait_rx

  // One character with a given width, ninth bit and polarity
  task automatic t_frame(input logic nine, input logic ninth, input logic inv, input logic [7:0] d);
    logic [7:0] n;
    n = cnt + 8'h01;
    @(posedge clk_i);
    ctrl.nine_bit_select <= nine;
    ctrl.ninth_data_bit  <= ninth;
    ctrl.transmit_invert <= inv;
    send(d);
    chk_bit(sef, 1'b0);
    wait_rx(n);
    chk_data(rx, {nine & ninth, d});
    repeat (BT) @(posedge clk_i);
    #1;
    chk_bit(sef, 1'b1);
  endtask : t_frame

  // Second write waits in the holding register while the first shifts
  task automatic t_b2b();
    logic [7:0] n;
    n = cnt + 8'h01;
    send(8'ha5);
    send(8'h3c);
    chk_bit(tbf, 1'b0);
    wait_rx(n);
    chk_data(rx, 9'h0a5);
    wait_rx(n + 8'h01);
    chk_data(rx, 9'h03c);
    chk_bit(tbf, 1'b1);
  endtask : t_b2b

  // Every combination of the three gates
  task automatic t_irq();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      irq_en <= 3'(i);
      @(posedge clk_i);
      #1;
      chk_bit(irq, i == 7);
    end
  endtask : t_irq

  // Port off refuses the load but keeps the data; enable off drops the flag
  task automatic t_refuse();
    logic [7:0] n;
    n = cnt + 8'h01;
    @(posedge clk_i);
    ctrl.serial_port_enable <= 1'b0;
    send(8'h5a);
    repeat (30) @(posedge clk_i);
    #1;
    chk_bit(sef, 1'b1);
    chk_bit(irq, 1'b0);
    @(posedge clk_i);
    ctrl.serial_port_enable <= 1'b1;
    wait_rx(n);
    chk_data(rx, 9'h05a);
    chk_bit(tbf, 1'b1);
    @(posedge clk_i);
    ctrl.transmit_enable <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk_bit(tbf, 1'b0);
    chk_bit(irq, 1'b0);
  endtask : t_refuse

  task automatic wrap_up();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    ctrl <= 8'h83;
    @(posedge clk_i);
    ctrl.transmit_enable <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk_bit(tbf, 1'b1);
    t_b2b();
    t_frame(1'b0, 1'b0, 1'b1, 8'h81);
    t_frame(1'b1, 1'b1, 1'b0, 8'h42);
    t_frame(1'b1, 1'b0, 1'b1, 8'hff);
    t_irq();
    t_refuse();
    wrap_up();
  end

  // Watchdog, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    wrap_up();
  end
endmodule : astx_transmitter_bench
`default_nettype wire
